// file: hw/mmp_mac_mii_port.sv
// MAC side of the MII nibble interface: byte streams to and from an external PHY
// What this block and the PHY do
// (RULE1) Drive one nibble per transmit clock while enabled
// (RULE2) PHY ignores transmit data while enable low
// (RULE3) Serial mode sends only on data bit 0
// (RULE4) PHY gives free receive clock for inputs
// (RULE5) Receive clock 25 or 2.5 MHz by rate; the PHY model uses one 30 ns period for every rate
// (RULE6) Serial mode receive clock runs at 10 MHz; the PHY model keeps its 30 ns period in serial mode
// (RULE7) Data valid stays high across whole frame
// (RULE8) Data valid drops right after final nibble
// (RULE9) Receive error with valid marks frame faulty
// (RULE10) Receive error ignored while data valid low
// (RULE11) Serial transceiver holds receive error low
// (RULE12) Capture one nibble per clock while valid
// (RULE13) Serial mode takes bits from bit 0
// (RULE14) PHY raises carrier sense while medium busy
// (RULE15) Enable drops at edge after final nibble
// (RULE16) Synchronise carrier sense before any use
// (RULE17) PHY raises collision input on collision
// (RULE18) Bytes pair nibbles, low nibble first
`timescale 1ns/1ns
module mmp_mac_mii_port (
  // System clock, reset, freeze
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // Configuration
  input  wire logic                          serial_encoder_decoder_mode,
  // Transmit byte stream from the MAC core
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  input  wire logic [mmp_pkg::BYTE_W-1:0]    tx_data,
  input  wire logic                          tx_last,
  // Receive byte stream to the MAC core
  output logic                               rx_valid,
  input  wire logic                          rx_ready,
  output logic      [mmp_pkg::BYTE_W-1:0]    rx_data,
  output logic                               rx_last,
  output logic                               rx_error,
  // Medium status
  output logic                               carrier_sense,
  output logic                               collision,
  // MII transmit
  input  wire logic                          mii_tx_clk,
  output logic                               mii_tx_en,
  output logic      [mmp_pkg::NIB_W-1:0]     mii_txd,
  // MII receive
  input  wire logic                          mii_rx_clk,
  input  wire logic                          mii_rx_dv,
  input  wire logic                          mii_rx_er,
  input  wire logic [mmp_pkg::NIB_W-1:0]     mii_rxd,
  // MII asynchronous status
  input  wire logic                          mii_crs,
  input  wire logic                          mii_col
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and mode cross into both link domains as levels
  logic rst_tx_s1_q, rst_tx_q, rst_rx_s1_q, rst_rx_q;
  logic mode_tx_s1_q, mode_tx_s2_q, mode_rx_s1_q, mode_rx_s2_q;

  always_ff @(posedge mii_tx_clk) begin
    rst_tx_s1_q  <= rst;
    rst_tx_q     <= rst_tx_s1_q;
    mode_tx_s1_q <= serial_encoder_decoder_mode;
    mode_tx_s2_q <= mode_tx_s1_q;
  end

  always_ff @(posedge mii_rx_clk) begin
    rst_rx_s1_q  <= rst;
    rst_rx_q     <= rst_rx_s1_q;
    mode_rx_s1_q <= serial_encoder_decoder_mode;
    mode_rx_s2_q <= mode_rx_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision change at any time, so two flops each
  logic crs_s1_q, col_s1_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      crs_s1_q      <= 1'b0;
      carrier_sense <= 1'b0;
      col_s1_q      <= 1'b0;
      collision     <= 1'b0;
    end else if (ce) begin
      crs_s1_q      <= mii_crs;  // RULE16
      carrier_sense <= crs_s1_q;
      col_s1_q      <= mii_col;
      collision     <= col_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers between the system clock and each link clock
  logic                     txf_r_valid, txf_r_ready;
  logic [mmp_pkg::TXW-1:0]  txf_r_data;
  logic                     rxf_w_valid, rxf_w_ready;
  logic [mmp_pkg::RXW-1:0]  rxf_w_data, rxf_r_data;

  mmp_async_fifo #(.WIDTH(mmp_pkg::TXW), .DEPTH(mmp_pkg::BUF_DEPTH)) u_tx_buf (
    .wclk    (clk),
    .wrst    (rst),
    .wce     (ce),
    .w_valid (tx_valid),
    .w_ready (tx_ready),
    .w_data  ({tx_last, tx_data}),
    .rclk    (mii_tx_clk),
    .rrst    (rst_tx_q),
    .rce     (1'b1),
    .r_valid (txf_r_valid),
    .r_ready (txf_r_ready),
    .r_data  (txf_r_data)
  );

  mmp_async_fifo #(.WIDTH(mmp_pkg::RXW), .DEPTH(mmp_pkg::BUF_DEPTH)) u_rx_buf (
    .wclk    (mii_rx_clk),
    .wrst    (rst_rx_q),
    .wce     (1'b1),
    .w_valid (rxf_w_valid),
    .w_ready (rxf_w_ready),
    .w_data  (rxf_w_data),
    .rclk    (clk),
    .rrst    (rst),
    .rce     (ce),
    .r_valid (rx_valid),
    .r_ready (rx_ready),
    .r_data  (rxf_r_data)
  );

  // Error flag is cumulative over the frame; it is final on the last byte
  assign rx_data  = rxf_r_data[mmp_pkg::BYTE_W-1:0];
  assign rx_error = rxf_r_data[mmp_pkg::RX_ERR_BIT];
  assign rx_last  = rxf_r_data[mmp_pkg::RX_LAST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer on the PHY transmit clock
  mmp_pkg::mmp_tx_state_e           tx_state_q, tx_state_d;
  logic [mmp_pkg::BYTE_W-1:0]       tx_byte_q, tx_byte_d;
  logic [2:0]                       tx_idx_q, tx_idx_d;
  logic                             tx_lastw_q, tx_lastw_d;
  logic                             mode_tx_q, mode_tx_d;
  logic                             tx_en_d;
  logic [mmp_pkg::NIB_W-1:0]        txd_d;

  // Mode is latched between frames so a change never splits a byte
  always_comb begin
    tx_state_d  = tx_state_q;
    tx_byte_d   = tx_byte_q;
    tx_idx_d    = tx_idx_q;
    tx_lastw_d  = tx_lastw_q;
    mode_tx_d   = mode_tx_q;
    tx_en_d     = 1'b0;
    txd_d       = mmp_pkg::NIB_RST;
    txf_r_ready = 1'b0;
    unique case (tx_state_q)
      mmp_pkg::MMP_TX_IDLE: begin
        mode_tx_d = mode_tx_s2_q;
        if (txf_r_valid) begin
          txf_r_ready = 1'b1;
          tx_byte_d   = txf_r_data[mmp_pkg::BYTE_W-1:0];
          tx_lastw_d  = txf_r_data[mmp_pkg::TX_LAST_BIT];
          tx_idx_d    = mmp_pkg::IDX_RST;
          tx_state_d  = mmp_pkg::MMP_TX_SEND;
        end
      end
      mmp_pkg::MMP_TX_SEND: begin
        tx_en_d = 1'b1;  // RULE1
        if (mode_tx_q) begin
          txd_d = {3'h0, tx_byte_q[tx_idx_q]};  // RULE3
        end else begin
          txd_d = tx_idx_q[0] ? tx_byte_q[7:4] : tx_byte_q[3:0];  // RULE18
        end
        if (tx_idx_q != (mode_tx_q ? mmp_pkg::SER_LAST_IDX : mmp_pkg::MII_LAST_IDX)) begin
          tx_idx_d = 3'(tx_idx_q + 3'h1);
        end else if (!tx_lastw_q && txf_r_valid) begin
          txf_r_ready = 1'b1;
          tx_byte_d   = txf_r_data[mmp_pkg::BYTE_W-1:0];
          tx_lastw_d  = txf_r_data[mmp_pkg::TX_LAST_BIT];
          tx_idx_d    = mmp_pkg::IDX_RST;
        end else begin
          // Final unit, or an underrun: enable falls one edge after this unit is driven
          tx_state_d = mmp_pkg::MMP_TX_IDLE;  // RULE15
        end
      end
    endcase
  end

  always_ff @(posedge mii_tx_clk) begin
    if (rst_tx_q) begin
      tx_state_q <= mmp_pkg::MMP_TX_IDLE;
      tx_byte_q  <= mmp_pkg::BYTE_RST;
      tx_idx_q   <= mmp_pkg::IDX_RST;
      tx_lastw_q <= 1'b0;
      mode_tx_q  <= 1'b0;
      mii_tx_en  <= 1'b0;
      mii_txd    <= mmp_pkg::NIB_RST;
    end else begin
      tx_state_q <= tx_state_d;
      tx_byte_q  <= tx_byte_d;
      tx_idx_q   <= tx_idx_d;
      tx_lastw_q <= tx_lastw_d;
      mode_tx_q  <= mode_tx_d;
      mii_tx_en  <= tx_en_d;
      mii_txd    <= txd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive assembler on the PHY receive clock; the PHY cannot be stalled,
  // so a word that meets a full buffer is dropped and later words marked bad; a dropped last word goes unmarked
  logic [2:0]                  rx_cnt_q, rx_cnt_d;
  logic [mmp_pkg::BYTE_W-1:0]  rx_sh_q, rx_sh_d, rx_held_q, rx_held_d, rx_byte_in;
  logic                        rx_held_v_q, rx_held_v_d, rx_err_q, rx_err_d;
  logic                        rx_dv_q, mode_rx_q, mode_rx_d, rx_complete;

  always_comb begin
    rx_cnt_d    = rx_cnt_q;
    rx_sh_d     = rx_sh_q;
    rx_held_d   = rx_held_q;
    rx_held_v_d = rx_held_v_q;
    rx_err_d    = rx_err_q;
    mode_rx_d   = mode_rx_q;
    rx_byte_in  = mmp_pkg::BYTE_RST;
    rx_complete = 1'b0;
    rxf_w_valid = 1'b0;
    rxf_w_data  = {1'b0, rx_err_q, rx_held_q};
    if (mii_rx_dv) begin
      if (mii_rx_er) begin
        rx_err_d = 1'b1;  // RULE9
      end
      if (mode_rx_q) begin
        rx_byte_in  = {mii_rxd[0], rx_sh_q[7:1]};  // RULE13
        rx_complete = rx_cnt_q == mmp_pkg::SER_LAST_IDX;
      end else begin
        rx_byte_in  = {mii_rxd, rx_sh_q[7:4]};  // RULE12 RULE18
        rx_complete = rx_cnt_q == mmp_pkg::MII_LAST_IDX;
      end
      rx_sh_d = rx_byte_in;
      if (rx_complete) begin
        rx_cnt_d    = mmp_pkg::IDX_RST;
        rx_held_d   = rx_byte_in;
        rx_held_v_d = 1'b1;
        // One byte is held back until we know whether it is the last
        if (rx_held_v_q) begin
          rxf_w_valid = 1'b1;
          if (!rxf_w_ready) begin
            rx_err_d = 1'b1;
          end
        end
      end else begin
        rx_cnt_d = 3'(rx_cnt_q + 3'h1);
      end
    end else begin
      // Error input is not looked at here; an odd trailing nibble is dropped
      mode_rx_d   = mode_rx_s2_q;  // RULE10
      rx_cnt_d    = mmp_pkg::IDX_RST;
      rx_held_v_d = 1'b0;
      rx_err_d    = 1'b0;
      if (rx_dv_q) begin
        rxf_w_valid = rx_held_v_q;
        rxf_w_data  = {1'b1, rx_err_q, rx_held_q};
      end
    end
  end

  always_ff @(posedge mii_rx_clk) begin
    if (rst_rx_q) begin
      rx_cnt_q    <= mmp_pkg::IDX_RST;
      rx_sh_q     <= mmp_pkg::BYTE_RST;
      rx_held_q   <= mmp_pkg::BYTE_RST;
      rx_held_v_q <= 1'b0;
      rx_err_q    <= 1'b0;
      rx_dv_q     <= 1'b0;
      mode_rx_q   <= 1'b0;
    end else begin
      rx_cnt_q    <= rx_cnt_d;
      rx_sh_q     <= rx_sh_d;
      rx_held_q   <= rx_held_d;
      rx_held_v_q <= rx_held_v_d;
      rx_err_q    <= rx_err_d;
      rx_dv_q     <= mii_rx_dv;
      mode_rx_q   <= mode_rx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the transmit side
  property p_tx_min_run;
    @(posedge mii_tx_clk) disable iff (rst_tx_q)
      ($rose(mii_tx_en) && !mode_tx_q) |-> mii_tx_en[*2];
  endproperty
  a_tx_min_run: assert property (p_tx_min_run) else $error("tx enable shorter than one byte"); // RULE1

  property p_tx_serial_upper;
    @(posedge mii_tx_clk) disable iff (rst_tx_q)
      (mii_tx_en && mode_tx_q) |-> (mii_txd[3:1] == 3'h0);
  endproperty
  a_tx_serial_upper: assert property (p_tx_serial_upper) else $error("upper tx bits used in serial mode"); // RULE3

  property p_tx_low_first;
    @(posedge mii_tx_clk) disable iff (rst_tx_q)
      (tx_state_q == mmp_pkg::MMP_TX_SEND && !mode_tx_q && tx_idx_q == 3'h0)
        |=> (mii_txd == $past(tx_byte_q[3:0])) ##1 (mii_txd == $past(tx_byte_q[7:4], 2));
  endproperty
  a_tx_low_first: assert property (p_tx_low_first) else $error("tx nibble order wrong"); // RULE18

  property p_tx_end;
    @(posedge mii_tx_clk) disable iff (rst_tx_q)
      $fell(tx_state_q == mmp_pkg::MMP_TX_SEND) |-> mii_tx_en ##1 !mii_tx_en;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx enable not dropped after final nibble"); // RULE15

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the receive side and on carrier sense
  property p_rx_err_set;
    @(posedge mii_rx_clk) disable iff (rst_rx_q)
      (mii_rx_dv && mii_rx_er) |=> rx_err_q;
  endproperty
  a_rx_err_set: assert property (p_rx_err_set) else $error("receive error not recorded"); // RULE9

  property p_rx_err_ignored;
    @(posedge mii_rx_clk) disable iff (rst_rx_q)
      (!mii_rx_dv && !rx_dv_q) |-> !rx_err_q;
  endproperty
  a_rx_err_ignored: assert property (p_rx_err_ignored) else $error("error taken outside a frame"); // RULE10

  property p_rx_nibble_pair;
    @(posedge mii_rx_clk) disable iff (rst_rx_q)
      (mii_rx_dv && !mode_rx_q && rx_cnt_q == 3'h1)
        |=> rx_held_v_q && (rx_held_q == {$past(mii_rxd), $past(mii_rxd, 2)});
  endproperty
  a_rx_nibble_pair: assert property (p_rx_nibble_pair) else $error("rx byte not built low nibble first"); // RULE12

  property p_rx_serial_bit;
    @(posedge mii_rx_clk) disable iff (rst_rx_q)
      (mii_rx_dv && mode_rx_q && rx_cnt_q == 3'h7) |=> (rx_held_q[7] == $past(mii_rxd[0]));
  endproperty
  a_rx_serial_bit: assert property (p_rx_serial_bit) else $error("serial rx bit not from bit 0"); // RULE13

  property p_rx_last_push;
    @(posedge mii_rx_clk) disable iff (rst_rx_q)
      (!mii_rx_dv && rx_dv_q && rx_held_v_q) |-> rxf_w_valid && rxf_w_data[mmp_pkg::RX_LAST_BIT];
  endproperty
  a_rx_last_push: assert property (p_rx_last_push) else $error("last byte not pushed at frame end"); // RULE12

  property p_crs_sync;
    @(posedge clk) disable iff (rst)
      ($rose(carrier_sense) && $past(ce) && $past(ce, 2)) |-> $past(mii_crs, 2);
  endproperty
  a_crs_sync: assert property (p_crs_sync) else $error("carrier sense not two flops behind pin"); // RULE16

  // Main scenarios
  c_tx_frame_end: cover property (@(posedge mii_tx_clk) disable iff (rst_tx_q) $fell(mii_tx_en));
  c_tx_serial:    cover property (@(posedge mii_tx_clk) disable iff (rst_tx_q) mii_tx_en && mode_tx_q);
  c_rx_bad_frame: cover property (@(posedge mii_rx_clk) disable iff (rst_rx_q)
                                  rxf_w_valid && rxf_w_data[mmp_pkg::RX_LAST_BIT] && rxf_w_data[mmp_pkg::RX_ERR_BIT]);

endmodule

// file: hw/mmp_pkg.sv
// Shared constants and types for the MII nibble port of the MAC
package mmp_pkg;

  // Data path widths
  localparam int NIB_W  = 4;
  localparam int BYTE_W = 8;

  // Buffer words: tx carries {last, byte}, rx carries {last, error, byte}
  localparam int TXW          = 9;
  localparam int RXW          = 10;
  localparam int TX_LAST_BIT  = 8;
  localparam int RX_ERR_BIT   = 8;
  localparam int RX_LAST_BIT  = 9;
  localparam int BUF_DEPTH    = 2;

  // Index of the final unit of a byte: two nibbles, or eight serial bits
  localparam logic [2:0] MII_LAST_IDX = 3'h1;
  localparam logic [2:0] SER_LAST_IDX = 3'h7;

  // Values after reset
  localparam logic [2:0]        IDX_RST  = 3'h0;
  localparam logic [NIB_W-1:0]  NIB_RST  = 4'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // System clock period, kept for reference; no check or logic reads it
  localparam int CLK_PERIOD_NS = 4;

  // Transmit sequencer states
  typedef enum logic [0:0] {
    MMP_TX_IDLE = 1'b0,
    MMP_TX_SEND = 1'b1
  } mmp_tx_state_e;

endpackage

// file: hw/mmp_async_fifo.sv
// Two-clock buffer with gray-coded pointers, valid and ready on both sides
`timescale 1ns/1ns
module mmp_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Write side
  input  wire logic             wclk,
  input  wire logic             wrst,
  input  wire logic             wce,
  input  wire logic             w_valid,
  output logic                  w_ready,
  input  wire logic [WIDTH-1:0] w_data,
  // Read side
  input  wire logic             rclk,
  input  wire logic             rrst,
  input  wire logic             rce,
  output logic                  r_valid,
  input  wire logic             r_ready,
  output logic      [WIDTH-1:0] r_data
);
  // DEPTH must be a power of two
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef logic [AW:0] mmp_ptr_t;

  logic     [WIDTH-1:0] mem_q [DEPTH];
  mmp_ptr_t             wbin_q, wbin_d, wgray_q, rbin_q, rbin_d, rgray_q;
  mmp_ptr_t             rgray_s1_q, rgray_s2_q, wgray_s1_q, wgray_s2_q;
  mmp_ptr_t             rbin_seen;

  function automatic mmp_ptr_t bin2gray(input mmp_ptr_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic mmp_ptr_t gray2bin(input mmp_ptr_t g);
    mmp_ptr_t b;
    b = g;
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write domain: full when pointers differ by exactly DEPTH
  always_comb begin
    rbin_seen = gray2bin(rgray_s2_q);
    // No room offered in reset, so a word is never taken and then lost
    w_ready   = !wrst && ((wbin_q ^ rbin_seen) != {1'b1, {AW{1'b0}}});
    wbin_d    = (w_valid && w_ready) ? mmp_ptr_t'(wbin_q + 1'b1) : wbin_q;
  end

  always_ff @(posedge wclk) begin
    if (wrst) begin
      wbin_q     <= '0;
      wgray_q    <= '0;
      rgray_s1_q <= '0;
      rgray_s2_q <= '0;
    end else if (wce) begin
      wbin_q     <= wbin_d;
      wgray_q    <= bin2gray(wbin_d);
      rgray_s1_q <= rgray_q;
      rgray_s2_q <= rgray_s1_q;
    end
  end

  // Storage needs no reset; a slot is only read after its pointer crossed
  always_ff @(posedge wclk) begin
    if (wce && w_valid && w_ready) begin
      mem_q[wbin_q[AW-1:0]] <= w_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read domain: empty when own gray pointer equals the synced write pointer
  always_comb begin
    r_valid = rgray_q != wgray_s2_q;
    r_data  = mem_q[rbin_q[AW-1:0]];
    rbin_d  = (r_valid && r_ready) ? mmp_ptr_t'(rbin_q + 1'b1) : rbin_q;
  end

  always_ff @(posedge rclk) begin
    if (rrst) begin
      rbin_q     <= '0;
      rgray_q    <= '0;
      wgray_s1_q <= '0;
      wgray_s2_q <= '0;
    end else if (rce) begin
      rbin_q     <= rbin_d;
      rgray_q    <= bin2gray(rbin_d);
      wgray_s1_q <= wgray_q;
      wgray_s2_q <= wgray_s1_q;
    end
  end

endmodule

// file: tb/mmp_phy_model.sv
// External PHY stand-in: link clocks, receive frames, transmit capture, medium status
`timescale 1ns/1ns
module mmp_phy_model (
  // Transmit side from the MAC
  input  wire logic       mii_tx_en,
  input  wire logic [3:0] mii_txd,
  // Link clocks and receive side to the MAC
  output logic            mii_tx_clk,
  output logic            mii_rx_clk,
  output logic            mii_rx_dv,
  output logic            mii_rx_er,
  output logic      [3:0] mii_rxd,
  // Medium status, asynchronous to every clock
  output logic            mii_crs,
  output logic            mii_col
);
  logic [3:0] txq[$];
  logic       busy;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running link clocks, 30 ns, phases unrelated to the system clock
  initial begin
    mii_rx_clk = 1'b0;
    mii_tx_clk = 1'b0;
    mii_rx_dv  = 1'b0;
    mii_rx_er  = 1'b1; // High while idle, except after a serial frame, so a leak into a frame shows
    mii_rxd    = 4'h0;
    mii_crs    = 1'b0;
    mii_col    = 1'b0;
    busy       = 1'b0;
    #8;
    forever #15 mii_tx_clk = ~mii_tx_clk;
  end

  // Receive clock never stops, also between frames
  // One period stands in for every rate; nothing in the port depends on it
  always #15 mii_rx_clk = ~mii_rx_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Released data lines change every period so a stale value cannot pass
  always @(negedge mii_rx_clk) begin
    if (!busy) begin
      mii_rxd = mii_rxd + 4'h3;
    end
  end

  // Only units qualified by enable count as frame data
  always @(posedge mii_tx_clk) begin
    if (mii_tx_en === 1'b1) begin
      txq.push_back(mii_txd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, low nibble first; serial units carry junk on the upper bits
  task automatic rx_frame(input logic [7:0] b[$], input int err_at, input logic ser);
    int k;
    int n;
    n = ser ? 8 : 2;
    @(posedge mii_rx_clk);
    #1;
    busy = 1'b1;
    for (k = 0; k < b.size() * n; k++) begin
      mii_rx_dv = 1'b1;
      mii_rx_er = (k == err_at) && !ser;
      mii_rxd = ser ? {mii_rxd[3:1] + 3'h5, b[k/8][k%8]} : (k[0] ? b[k/2][7:4] : b[k/2][3:0]);
      @(posedge mii_rx_clk);
      #1;
    end
    mii_rx_dv = 1'b0;
    mii_rx_er = !ser;
    mii_rxd = ~mii_rxd;
    busy = 1'b0;
  endtask

  // Medium status levels
  task automatic set_status(input logic crs, input logic col);
    mii_crs = crs;
    mii_col = col;
  endtask
endmodule

// file: tb/tb_mmp_mac_mii_port.sv
// Self-checking bench for the MAC nibble port against a PHY model
`timescale 1ns/1ns
module tb_mmp_mac_mii_port;
  logic       clk, rst, ce, mode, tx_valid, tx_ready, tx_last;
  logic       rx_valid, rx_ready, rx_last, rx_error, carrier_sense, collision;
  logic [7:0] tx_data, rx_data;
  logic       mii_tx_clk, mii_tx_en, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_col;
  logic [3:0] mii_txd, mii_rxd;
  logic [9:0] rxq[$];
  logic       st;
  int         n_fail, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // System clock, 4 ns
  initial clk = 1'b0;
  always #2 clk = ~clk;

  mmp_mac_mii_port DUT (.clk(clk), .rst(rst), .ce(ce), .serial_encoder_decoder_mode(mode),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .rx_error(rx_error), .carrier_sense(carrier_sense), .collision(collision),
    .mii_tx_clk(mii_tx_clk), .mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_rx_clk(mii_rx_clk),
    .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd), .mii_crs(mii_crs),
    .mii_col(mii_col));

  mmp_phy_model PHY (.mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_tx_clk(mii_tx_clk),
    .mii_rx_clk(mii_rx_clk), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd),
    .mii_crs(mii_crs), .mii_col(mii_col));

  // Collect every word the consumer takes, as {last, error, byte}
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && ce === 1'b1) begin
      rxq.push_back({rx_last, rx_error, rx_data});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons, one per kind of result
  task automatic chk_rx(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t rx word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_tx(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t tx unit %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Offer one frame; request held until the edge that sees ready, stall noted
  task automatic tx_send(input logic [7:0] b[$], output logic stalled);
    int i;
    int w;
    stalled = 1'b0;
    for (i = 0; i < b.size(); i++) begin
      tx_valid = 1'b1;
      tx_data = b[i];
      tx_last = (i == b.size() - 1);
      w = 0;
      @(posedge clk);
      while (tx_ready !== 1'b1 && w < 500) begin
        stalled = 1'b1;
        @(posedge clk);
        w++;
      end
      #1;
    end
    tx_valid = 1'b0;
  endtask

  // Units seen on the wire, none more; a late enable drop adds one
  task automatic tx_expect(input logic [3:0] exp[$]);
    int w;
    w = 0;
    while (PHY.txq.size() < exp.size() && w < 2000) begin
      @(posedge clk);
      w++;
    end
    repeat (100) @(posedge clk);
    chk_flag(PHY.txq.size() == exp.size(), 1'b1);
    foreach (exp[i]) chk_tx(PHY.txq[i], exp[i]);
    PHY.txq.delete();
  endtask

  // Words taken by the consumer, in order and complete
  task automatic rx_expect(input logic [9:0] exp[$]);
    int w;
    w = 0;
    while (rxq.size() < exp.size() && w < 1000) begin
      @(posedge clk);
      w++;
    end
    repeat (20) @(posedge clk);
    #1;
    chk_flag(rxq.size() == exp.size(), 1'b1);
    foreach (exp[i]) chk_rx(rxq[i], exp[i]);
    rxq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Three bytes back to back: buffer refuses the third until a pop
  task automatic t_tx_nibble();
    tx_send('{8'hA5, 8'h3C, 8'h0F}, st);
    chk_flag(st, 1'b1);
    tx_expect('{4'h5, 4'hA, 4'hC, 4'h3, 4'hF, 4'h0});
  endtask

  // Faulty frame flags every word, then an idle error level must not leak
  task automatic t_rx_nibble();
    PHY.rx_frame('{8'hAB, 8'hCD, 8'hEF}, 0, 1'b0);
    rx_expect('{10'h1AB, 10'h1CD, 10'h3EF});
    PHY.rx_frame('{8'h12, 8'h34}, -1, 1'b0);
    rx_expect('{10'h012, 10'h234});
  endtask

  // Consumer stalls a whole frame; both words must survive in the buffer
  task automatic t_rx_stall();
    rx_ready = 1'b0;
    PHY.rx_frame('{8'h81, 8'h7E}, -1, 1'b0);
    repeat (30) @(posedge clk);
    chk_flag(rx_valid, 1'b1);
    #1;
    rx_ready = 1'b1;
    rx_expect('{10'h081, 10'h27E});
  endtask

  // Status passes two flops: frozen while ce is low, settled three edges after
  task automatic t_status();
    ce = 1'b0;
    PHY.set_status(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk_flag(carrier_sense, 1'b0);
    ce = 1'b1;
    @(posedge clk);
    #1;
    chk_flag(carrier_sense, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk_flag(carrier_sense, 1'b1);
    PHY.set_status(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk_flag(collision, 1'b1);
    PHY.set_status(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk_flag(carrier_sense | collision, 1'b0);
  endtask

  // Serial transmit: bit 0 only, least significant first, upper bits zero
  task automatic t_tx_serial();
    logic [7:0] b[$];
    logic [3:0] e[$];
    b = '{8'hA5, 8'h01};
    for (int k = 0; k < 16; k++) e.push_back({3'b000, b[k/8][k%8]});
    tx_send(b, st);
    tx_expect(e);
  endtask

  // Serial receive: upper data lines carry junk and must be ignored
  task automatic t_rx_serial();
    PHY.rx_frame('{8'h5A, 8'hC3}, -1, 1'b1);
    rx_expect('{10'h05A, 10'h2C3});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset spans 160 ns so the 30 ns link domains see 5 edges
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    mode = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    rx_ready = 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk_flag(tx_ready | rx_valid | mii_tx_en | carrier_sense, 1'b0);
    rst = 1'b0;
    repeat (40) @(posedge clk);
    #1;
    t_tx_nibble();
    t_rx_nibble();
    t_rx_stall();
    t_status();
    mode = 1'b1;
    repeat (100) @(posedge clk);
    #1;
    t_tx_serial();
    t_rx_serial();
    give_verdict();
  end

  // Watchdog, far beyond the few microseconds the sequence needs
  initial begin
    #100000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule
